// *** verilog/asr_pkg.sv ***
// Constants for the serial receiver: register map, field positions and sampling phases
package asr_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_SERIAL_CONTROL_ONE   = 8'h00;
  localparam logic [7:0] OFF_SERIAL_CONTROL_TWO   = 8'h04;
  localparam logic [7:0] OFF_SERIAL_STATUS_ONE    = 8'h08;
  localparam logic [7:0] OFF_RX_BUFFER            = 8'h0C;
  localparam logic [7:0] OFF_SERIAL_CONTROL_THREE = 8'h10;

  // serial_control_one fields
  localparam int BIT_NINE_BIT_MODE = 0;
  localparam int BIT_RX_ENABLE     = 1;
  // serial_control_two fields
  localparam int BIT_RX_IRQ_ENABLE = 0;
  // serial_status_one fields
  localparam int BIT_RX_FULL       = 0;
  localparam int BIT_NOISE         = 1;
  localparam int BIT_FRAMING       = 2;
  localparam int BIT_BREAK         = 3;
  // serial_control_three fields
  localparam int BIT_RX_NINTH      = 0;

  // Reset values
  localparam logic [1:0] RST_CONTROL_ONE = 2'h0;
  localparam logic       RST_CONTROL_TWO = 1'b0;

  // Sampling phases within one bit, counted 1 to 16
  localparam logic [4:0] PH_FIRST  = 5'h01;
  localparam logic [4:0] PH_START1 = 5'h03;
  localparam logic [4:0] PH_START2 = 5'h05;
  localparam logic [4:0] PH_START3 = 5'h07;
  localparam logic [4:0] PH_DATA1  = 5'h08;
  localparam logic [4:0] PH_DATA2  = 5'h09;
  localparam logic [4:0] PH_DATA3  = 5'h0A;
  localparam logic [4:0] PH_LATE   = 5'h0C;
  localparam logic [4:0] PH_EARLY  = 5'h04;
  localparam logic [4:0] PH_LAST   = 5'h10;

  // Bit positions within a frame: 0 is the start bit
  localparam logic [3:0] IDX_STOP_8 = 4'h9;
  localparam logic [3:0] IDX_STOP_9 = 4'hA;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {
    ST_SEARCH = 1'b0,
    ST_RECV   = 1'b1
  } asr_state_type;

endpackage

// *** verilog/asr_vote3.sv ***
// Three-sample majority vote with disagreement detect
`timescale 1ns/1ps
`default_nettype none

module asr_vote3 (
  input  wire logic [2:0] i_samples,
  output logic            o_majority,
  output logic            o_noisy
);

  assign o_majority = (i_samples[0] & i_samples[1]) | (i_samples[0] & i_samples[2])
                    | (i_samples[1] & i_samples[2]);
  assign o_noisy    = ~((i_samples == 3'h0) | (i_samples == 3'h7));

endmodule

`default_nettype wire

// *** verilog/asr_rx.sv ***
// Asynchronous serial receiver with start-bit verification, majority sampling, AXI4-Lite regs
//
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module asr_rx #(
  parameter int SYNC_STAGES = 2
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset,
  input  wire logic        i_sample_tick,
  input  wire logic        i_rx_serial,
  output logic             o_rx_irq,
  input  wire logic [7:0]  i_s_axi_awaddr,
  input  wire logic        i_s_axi_awvalid,
  output logic             o_s_axi_awready,
  input  wire logic [31:0] i_s_axi_wdata,
  input  wire logic [3:0]  i_s_axi_wstrb,
  input  wire logic        i_s_axi_wvalid,
  output logic             o_s_axi_wready,
  output logic [1:0]       o_s_axi_bresp,
  output logic             o_s_axi_bvalid,
  input  wire logic        i_s_axi_bready,
  input  wire logic [7:0]  i_s_axi_araddr,
  input  wire logic        i_s_axi_arvalid,
  output logic             o_s_axi_arready,
  output logic [31:0]      o_s_axi_rdata,
  output logic [1:0]       o_s_axi_rresp,
  output logic             o_s_axi_rvalid,
  input  wire logic        i_s_axi_rready
);

  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("SYNC_STAGES must be at least 2");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register state

  logic                      nine_bit_mode;
  logic                      rx_enable;
  logic                      rx_irq_enable;
  logic                      rx_full_flag;
  logic                      noise_flag;
  logic                      framing_err_flag;
  logic                      break_flag;
  logic [7:0]                rx_buffer;
  logic                      rx_ninth_bit;

  ////////////////////////////////////////////////////////////////////////////////
  // Input synchronizer

  logic [SYNC_STAGES-1:0]    sync_chain;
  logic                      rx_sync;

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      sync_chain <= '1;
    end else begin
      sync_chain <= {sync_chain[SYNC_STAGES-2:0], i_rx_serial};
    end
  end
  assign rx_sync = sync_chain[SYNC_STAGES-1];

  ////////////////////////////////////////////////////////////////////////////////
  // Receive sequencer

  asr_pkg::asr_state_type    state;
  logic [4:0]                phase;
  logic [4:0]                next_phase;
  logic [3:0]                bit_idx;
  logic [3:0]                stop_idx;
  logic [2:0]                history;
  logic [1:0]                vote_hold;
  logic                      vote_maj;
  logic                      vote_noisy;
  logic [8:0]                shift_reg;
  logic                      last_bit;
  logic                      noise_acc;
  logic                      tick_recv;
  logic                      fall_edge;
  logic                      realign_late;
  logic                      realign_early;
  logic                      start_found;
  logic                      start_reject;
  logic                      stop_done;
  logic                      is_break;
  logic                      buf_read;

  asr_vote3 u_vote (
    .i_samples  ({vote_hold, rx_sync}),
    .o_majority (vote_maj),
    .o_noisy    (vote_noisy)
  );

  // Phase of the sample taken at this tick
  assign next_phase = (phase == asr_pkg::PH_LAST) ? asr_pkg::PH_FIRST : phase + 5'h01;
  assign stop_idx   = nine_bit_mode ? asr_pkg::IDX_STOP_9 : asr_pkg::IDX_STOP_8;
  assign tick_recv  = i_sample_tick && (state == asr_pkg::ST_RECV);
  assign start_found = i_sample_tick && rx_enable && (state == asr_pkg::ST_SEARCH)
                     && !rx_sync && (history == 3'h7);
  assign start_reject = tick_recv && (bit_idx == 4'h0)
                      && (next_phase == asr_pkg::PH_START3) && vote_maj;
  assign stop_done  = tick_recv && (bit_idx == stop_idx)
                    && (next_phase == asr_pkg::PH_DATA3);
  assign fall_edge  = history[0] && !rx_sync;
  // A 1-to-0 change lands near the bit boundary; snap the counter to it
  assign realign_late  = tick_recv && fall_edge && last_bit && (bit_idx != 4'h0)
                       && (bit_idx < stop_idx) && (next_phase >= asr_pkg::PH_LATE);
  assign realign_early = tick_recv && fall_edge && last_bit && (bit_idx >= 4'h2)
                       && (next_phase <= asr_pkg::PH_EARLY)
                       && (next_phase != asr_pkg::PH_FIRST);
  assign is_break   = (shift_reg == 9'h000) && !vote_maj;

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      history <= 3'h7;
    end else if (i_sample_tick) begin
      history <= {history[1:0], rx_sync};
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state   <= asr_pkg::ST_SEARCH;
      phase   <= asr_pkg::PH_FIRST;
      bit_idx <= 4'h0;
    end else if (start_found) begin
      state   <= asr_pkg::ST_RECV;
      phase   <= asr_pkg::PH_FIRST;
      bit_idx <= 4'h0;
    end else if (!rx_enable || start_reject || stop_done) begin
      state   <= asr_pkg::ST_SEARCH;
      phase   <= asr_pkg::PH_FIRST;
      bit_idx <= 4'h0;
    end else if (realign_late) begin
      phase   <= asr_pkg::PH_FIRST;
      bit_idx <= bit_idx + 4'h1;
    end else if (realign_early) begin
      phase   <= asr_pkg::PH_FIRST;
    end else if (tick_recv) begin
      phase <= next_phase;
      if (next_phase == asr_pkg::PH_FIRST) begin
        bit_idx <= bit_idx + 4'h1;
      end
    end
  end

  // Hold the first two of each three-sample group for the vote
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      vote_hold <= 2'h0;
    end else if (tick_recv && ((next_phase == asr_pkg::PH_START1)
                 || (next_phase == asr_pkg::PH_START2)
                 || (next_phase == asr_pkg::PH_DATA1)
                 || (next_phase == asr_pkg::PH_DATA2))) begin
      vote_hold <= {vote_hold[0], rx_sync};
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      shift_reg <= 9'h000;
      last_bit  <= 1'b0;
      noise_acc <= 1'b0;
    end else if (start_found) begin
      shift_reg <= 9'h000;
      last_bit  <= 1'b0;
      noise_acc <= 1'b0;
    end else if (tick_recv) begin
      if (bit_idx == 4'h0 && next_phase == asr_pkg::PH_START3 && vote_noisy && !vote_maj) begin
        noise_acc <= 1'b1;
      end
      if (next_phase == asr_pkg::PH_DATA3) begin
        if (bit_idx == 4'h0) begin
          if (vote_noisy || vote_maj) begin
            noise_acc <= 1'b1;
          end
        end else begin
          last_bit <= vote_maj;
          if (vote_noisy) begin
            noise_acc <= 1'b1;
          end
          if (bit_idx != stop_idx) begin
            shift_reg <= {vote_maj, shift_reg[8:1]};
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Character completion and flags

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      rx_buffer    <= 8'h00;
      rx_ninth_bit <= 1'b0;
    end else if (stop_done) begin
      if (is_break) begin
        rx_buffer    <= 8'h00;
        rx_ninth_bit <= 1'b0;
      end else if (nine_bit_mode) begin
        rx_buffer    <= shift_reg[7:0];
        rx_ninth_bit <= shift_reg[8];
      end else begin
        rx_buffer    <= shift_reg[8:1];
        rx_ninth_bit <= shift_reg[8];
      end
    end
  end

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      rx_full_flag <= 1'b0;
    end else if (stop_done) begin
      rx_full_flag <= 1'b1;
    end else if (buf_read) begin
      rx_full_flag <= 1'b0;
    end
  end

  logic                      status_w1c;
  logic [31:0]               wdata_q;

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      noise_flag       <= 1'b0;
      framing_err_flag <= 1'b0;
      break_flag       <= 1'b0;
    end else begin
      if (stop_done && (noise_acc || vote_noisy)) begin
        noise_flag <= 1'b1;
      end else if (status_w1c && wdata_q[asr_pkg::BIT_NOISE]) begin
        noise_flag <= 1'b0;
      end
      if (stop_done && !vote_maj) begin
        framing_err_flag <= 1'b1;
      end else if (status_w1c && wdata_q[asr_pkg::BIT_FRAMING]) begin
        framing_err_flag <= 1'b0;
      end
      if (stop_done && is_break) begin
        break_flag <= 1'b1;
      end else if (status_w1c && wdata_q[asr_pkg::BIT_BREAK]) begin
        break_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_rx_irq <= 1'b0;
    end else begin
      o_rx_irq <= (rx_full_flag || stop_done) && rx_irq_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel

  logic                      aw_held;
  logic                      w_held;
  logic [7:0]                awaddr_q;
  logic                      do_write;
  logic                      wdata_q_lane0;
  logic [3:0]                wstrb_q;

  assign wdata_q_lane0 = wstrb_q[0];
  assign do_write   = aw_held && w_held && !o_s_axi_bvalid;
  assign status_w1c = do_write && (awaddr_q == asr_pkg::OFF_SERIAL_STATUS_ONE)
                    && wdata_q_lane0;

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      aw_held  <= 1'b0;
      awaddr_q <= 8'h00;
    end else if (i_s_axi_awvalid && o_s_axi_awready) begin
      aw_held  <= 1'b1;
      awaddr_q <= i_s_axi_awaddr;
    end else if (do_write) begin
      aw_held  <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      w_held  <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (i_s_axi_wvalid && o_s_axi_wready) begin
      w_held  <= 1'b1;
      wdata_q <= i_s_axi_wdata;
      wstrb_q <= i_s_axi_wstrb;
    end else if (do_write) begin
      w_held  <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_s_axi_awready <= 1'b0;
      o_s_axi_wready  <= 1'b0;
    end else begin
      o_s_axi_awready <= !aw_held && !(i_s_axi_awvalid && o_s_axi_awready);
      o_s_axi_wready  <= !w_held && !(i_s_axi_wvalid && o_s_axi_wready);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp  <= asr_pkg::RESP_OKAY;
    end else if (do_write) begin
      o_s_axi_bvalid <= 1'b1;
      if (awaddr_q == asr_pkg::OFF_SERIAL_CONTROL_ONE
          || awaddr_q == asr_pkg::OFF_SERIAL_CONTROL_TWO
          || awaddr_q == asr_pkg::OFF_SERIAL_STATUS_ONE) begin
        o_s_axi_bresp <= asr_pkg::RESP_OKAY;
      end else begin
        o_s_axi_bresp <= asr_pkg::RESP_SLVERR;
      end
    end else if (i_s_axi_bready) begin
      o_s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      nine_bit_mode <= asr_pkg::RST_CONTROL_ONE[asr_pkg::BIT_NINE_BIT_MODE];
      rx_enable     <= asr_pkg::RST_CONTROL_ONE[asr_pkg::BIT_RX_ENABLE];
      rx_irq_enable <= asr_pkg::RST_CONTROL_TWO;
    end else if (do_write && wstrb_q[0]) begin
      if (awaddr_q == asr_pkg::OFF_SERIAL_CONTROL_ONE) begin
        nine_bit_mode <= wdata_q[asr_pkg::BIT_NINE_BIT_MODE];
        rx_enable     <= wdata_q[asr_pkg::BIT_RX_ENABLE];
      end else if (awaddr_q == asr_pkg::OFF_SERIAL_CONTROL_TWO) begin
        rx_irq_enable <= wdata_q[asr_pkg::BIT_RX_IRQ_ENABLE];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel

  logic                      do_read;
  assign do_read  = i_s_axi_arvalid && o_s_axi_arready;
  // Reading the buffer is what tells the block software has the byte
  assign buf_read = do_read && (i_s_axi_araddr == asr_pkg::OFF_RX_BUFFER);

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_s_axi_arready <= 1'b0;
    end else begin
      o_s_axi_arready <= !o_s_axi_rvalid && !do_read;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata  <= 32'h0000_0000;
      o_s_axi_rresp  <= asr_pkg::RESP_OKAY;
    end else if (do_read) begin
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_rresp  <= asr_pkg::RESP_OKAY;
      o_s_axi_rdata  <= 32'h0000_0000;
      if (i_s_axi_araddr == asr_pkg::OFF_SERIAL_CONTROL_ONE) begin
        o_s_axi_rdata[asr_pkg::BIT_NINE_BIT_MODE] <= nine_bit_mode;
        o_s_axi_rdata[asr_pkg::BIT_RX_ENABLE]     <= rx_enable;
      end else if (i_s_axi_araddr == asr_pkg::OFF_SERIAL_CONTROL_TWO) begin
        o_s_axi_rdata[asr_pkg::BIT_RX_IRQ_ENABLE] <= rx_irq_enable;
      end else if (i_s_axi_araddr == asr_pkg::OFF_SERIAL_STATUS_ONE) begin
        o_s_axi_rdata[asr_pkg::BIT_RX_FULL] <= rx_full_flag;
        o_s_axi_rdata[asr_pkg::BIT_NOISE]   <= noise_flag;
        o_s_axi_rdata[asr_pkg::BIT_FRAMING] <= framing_err_flag;
        o_s_axi_rdata[asr_pkg::BIT_BREAK]   <= break_flag;
      end else if (i_s_axi_araddr == asr_pkg::OFF_RX_BUFFER) begin
        o_s_axi_rdata[7:0] <= rx_buffer;
      end else if (i_s_axi_araddr == asr_pkg::OFF_SERIAL_CONTROL_THREE) begin
        o_s_axi_rdata[asr_pkg::BIT_RX_NINTH] <= rx_ninth_bit;
      end else begin
        o_s_axi_rresp <= asr_pkg::RESP_SLVERR;
      end
    end else if (i_s_axi_rready) begin
      o_s_axi_rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// *** tb/asr_rx_checker.sv ***
// Port assertions for the serial receiver, bound to its top module
`timescale 1ns/1ps
`default_nettype none

module asr_rx_checker (
  input wire logic        i_sys_clk,
  input wire logic        i_reset,
  input wire logic        i_sample_tick,
  input wire logic        i_rx_serial,
  input wire logic        o_rx_irq,
  input wire logic [7:0]  i_s_axi_awaddr,
  input wire logic        i_s_axi_awvalid,
  input wire logic        o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0]  i_s_axi_wstrb,
  input wire logic        i_s_axi_wvalid,
  input wire logic        o_s_axi_wready,
  input wire logic [1:0]  o_s_axi_bresp,
  input wire logic        o_s_axi_bvalid,
  input wire logic        i_s_axi_bready,
  input wire logic [7:0]  i_s_axi_araddr,
  input wire logic        i_s_axi_arvalid,
  input wire logic        o_s_axi_arready,
  input wire logic [31:0] o_s_axi_rdata,
  input wire logic [1:0]  o_s_axi_rresp,
  input wire logic        o_s_axi_rvalid,
  input wire logic        i_s_axi_rready
);
  logic [7:0] aw_q;
  logic [7:0] ar_q;
  logic [3:0] tick_age;
  logic [3:0] acc_age;

  ////////////////////////////////////////////////////////////////////////////////
  // Address of the access under way, for judging its response
  always_ff @(posedge i_sys_clk) begin
    if (i_s_axi_awvalid && o_s_axi_awready) aw_q <= i_s_axi_awaddr;
    if (i_s_axi_arvalid && o_s_axi_arready) ar_q <= i_s_axi_araddr;
  end

  // Ages saturate so a long idle stretch never wraps back into range
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) tick_age <= 4'hF;
    else if (i_sample_tick) tick_age <= 4'h0;
    else if (tick_age != 4'hF) tick_age <= tick_age + 4'h1;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) acc_age <= 4'hF;
    else if ((i_s_axi_wvalid && o_s_axi_wready) || (i_s_axi_arvalid && o_s_axi_arready))
      acc_age <= 4'h0;
    else if (acc_age != 4'hF) acc_age <= acc_age + 4'h1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking dc @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  sequence both_taken;
    i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
  endsequence
  sequence resp_due;
    !o_s_axi_awready ##1 o_s_axi_bvalid;
  endsequence
  property read_answer;
    i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid;
  endproperty

  write_walk_a: assert property (both_taken |=> resp_due)
    else $error("write response not two cycles after address and data");
  read_walk_a: assert property (read_answer)
    else $error("read data not one cycle after read address");
  write_resp_a: assert property ($rose(o_s_axi_bvalid) && aw_q != 8'h08 |->
    o_s_axi_bresp == ((aw_q == 8'h00 || aw_q == 8'h04) ? 2'h0 : 2'h2))
    else $error("write response code wrong for address");
  read_unmapped_a: assert property ($rose(o_s_axi_rvalid) && ar_q > 8'h10 |->
    o_s_axi_rresp == 2'h2 && o_s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  read_upper_a: assert property (o_s_axi_rvalid |-> o_s_axi_rdata[31:9] == 23'h0)
    else $error("read data upper bits not zero");
  irq_rise_a: assert property ($rose(o_rx_irq) |-> tick_age <= 4'h3 || acc_age <= 4'h5)
    else $error("interrupt rose without completion or enable write");
  irq_fall_a: assert property ($fell(o_rx_irq) |-> acc_age <= 4'h5)
    else $error("interrupt fell without register access");
  busy_refuse_a: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
    else $error("write accepted while response pending");
endmodule

bind asr_rx asr_rx_checker u_checker (.*);

`default_nettype wire

// *** tb/asr_tx_model.sv ***
// Remote transmitter model driving the receive line, one sample per tick
`timescale 1ns/1ps
`default_nettype none

module asr_tx_model (
  input  wire logic       i_clk,
  input  wire logic       i_tick,
  input  wire logic       i_go,
  input  wire logic [8:0] i_data,
  input  wire logic       i_nine,
  input  wire logic       i_stop,
  input  wire logic [3:0] i_noise_bit,
  input  wire logic       i_false_start,
  input  wire logic [1:0] i_skew,
  output logic            o_line,
  output logic            o_busy = 1'h0,
  output logic [8:0]      o_ticks = 9'h000
);
  logic        pend = 1'h0;
  logic        held = 1'h0;
  logic [3:0]  idx;
  logic [3:0]  ph;
  logic [10:0] frame_w;

  assign idx = o_ticks[7:4];
  assign ph = o_ticks[3:0];
  // Low start, data LSB first, then stop; idle high
  assign frame_w = i_nine ? {i_stop, i_data, 1'h0} : {1'h1, i_stop, i_data[7:0], 1'h0};

  // Noise flips only the ninth sample of a bit; a false start lasts two samples
  always_comb begin
    o_line = 1'h1;
    if (o_busy) begin
      o_line = frame_w[idx] ^ (idx == i_noise_bit && ph == 4'h8);
      if (i_false_start && idx == 4'h0 && ph >= 4'h2) o_line = 1'h1;
    end
  end

  // Frames begin on a tick so the receiver sees the edge at a known tick
  always @(posedge i_clk) begin
    if (i_go) pend <= 1'h1;
    if (i_tick && pend) begin
      pend <= 1'h0;
      o_busy <= 1'h1;
      o_ticks <= 9'h000;
    end else if (i_tick && o_busy) begin
      // Skew 1 drops, skew 2 repeats one tick per bit after the start bit, stop bit included: a fast or slow sender
      if (i_skew == 2'h2 && ph == 4'h0 && idx != 4'h0 && !held) begin
        held <= 1'h1;
      end else begin
        held <= 1'h0;
        o_ticks <= o_ticks + ((i_skew == 2'h1 && ph == 4'h0 && idx != 4'h0) ? 9'h002 : 9'h001);
        if (ph == 4'hF && idx == (i_nine ? 4'hA : 4'h9)) o_busy <= 1'h0;
      end
    end
  end
endmodule

`default_nettype wire

// *** tb/asr_rx_test.sv ***
// Bench for the serial receiver: register accesses and received frames
`timescale 1ns/1ps
`default_nettype none

module asr_rx_test;
  localparam int         LIMIT = 20000;
  localparam logic [1:0] OK    = asr_pkg::RESP_OKAY;
  localparam logic [1:0] SE    = asr_pkg::RESP_SLVERR;
  logic        sys_clk = 1'h0;
  logic        reset   = 1'h1;
  logic        tick    = 1'h0;
  logic [1:0]  tdiv    = 2'h0;
  logic [7:0]  awaddr  = 8'h00;
  logic [7:0]  araddr  = 8'h00;
  logic [31:0] wdata   = 32'h0;
  logic        awvalid = 1'h0;
  logic        wvalid  = 1'h0;
  logic        bready  = 1'h0;
  logic        arvalid = 1'h0;
  logic        rready  = 1'h0;
  logic        go      = 1'h0;
  logic [8:0]  tx_data = 9'h1FF;
  logic        tx_nine = 1'h0;
  logic        tx_stop = 1'h1;
  logic [3:0]  tx_nz   = 4'hF;
  logic        tx_fs   = 1'h0;
  logic [1:0]  tx_skew = 2'h0;
  logic        awready, wready, bvalid, arready, rvalid, irq, line, tx_busy, irq_seen;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [8:0]  tx_ticks, full_at;
  logic [3:0]  nzs [3] = '{4'h0, 4'h4, 4'h9};
  int          err_total = 0;
  int          n_compared = 0;
  int          cycles = 0;

  always #5 sys_clk = ~sys_clk;
  // One sample tick every four clocks: a 16x baud stand-in
  always @(posedge sys_clk) begin
    tdiv <= tdiv + 2'h1;
    tick <= (tdiv == 2'h3);
  end

  asr_rx uut (.i_sys_clk(sys_clk), .i_reset(reset), .i_sample_tick(tick), .i_rx_serial(line),
    .o_rx_irq(irq), .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
    .o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hF),
    .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
    .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready), .i_s_axi_araddr(araddr),
    .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
    .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready));
  asr_tx_model peer (.i_clk(sys_clk), .i_tick(tick), .i_go(go), .i_data(tx_data),
    .i_nine(tx_nine), .i_stop(tx_stop), .i_noise_bit(tx_nz), .i_false_start(tx_fs),
    .i_skew(tx_skew), .o_line(line), .o_busy(tx_busy), .o_ticks(tx_ticks));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t ns: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // The extra edge at the end keeps ready from being set twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    bready <= 1'h0;
    chk({30'h0, bresp}, {30'h0, er});
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rready <= 1'h0;
    chk(rdata, ed);
    chk({30'h0, rresp}, {30'h0, er});
    @(posedge sys_clk);
  endtask

  // Records the peer's tick count at the first interrupt of the frame
  task automatic send(input logic [8:0] d, input logic st, input logic [3:0] nz, input logic fs);
    tx_data <= d;
    tx_stop <= st;
    tx_nz <= nz;
    tx_fs <= fs;
    go <= 1'h1;
    @(posedge sys_clk);
    go <= 1'h0;
    irq_seen = 1'h0;
    repeat (8) @(posedge sys_clk);
    while (tx_busy) begin
      @(posedge sys_clk);
      if (irq && !irq_seen) begin
        irq_seen = 1'h1;
        full_at = tx_ticks;
      end
    end
    repeat (80) @(posedge sys_clk);
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      err_total++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge sys_clk);
    reset <= 1'h0;
    repeat (2) @(posedge sys_clk);
    rd(8'h00, 32'h0, OK);
    rd(8'h08, 32'h0, OK);
    rd(8'h14, 32'h0, SE);
    wr(8'h0C, 32'h5A, SE);
    wr(8'h00, 32'h2, OK);
    wr(8'h04, 32'h1, OK);
    $display("test registers done");
    send(9'h0A5, 1'h1, 4'hF, 1'h0);
    chk({23'h0, full_at}, 32'h9A);
    rd(8'h08, 32'h1, OK);
    rd(8'h10, 32'h1, OK);
    rd(8'h0C, 32'hA5, OK);
    rd(8'h08, 32'h0, OK);
    chk({31'h0, irq}, 32'h0);
    $display("test eight bit done");
    wr(8'h00, 32'h3, OK);
    tx_nine <= 1'h1;
    for (int i = 0; i < 2; i++) begin
      send(i ? 9'h15A : 9'h0A5, 1'h1, 4'hF, 1'h0);
      chk({23'h0, full_at}, 32'hAA);
      rd(8'h10, 32'(i), OK);
      rd(8'h0C, i ? 32'h5A : 32'hA5, OK);
    end
    wr(8'h00, 32'h2, OK);
    tx_nine <= 1'h0;
    $display("test nine bit done");
    for (int k = 0; k < 3; k++) begin
      send(9'h03C, 1'h1, nzs[k], 1'h0);
      rd(8'h08, 32'h3, OK);
      rd(8'h0C, 32'h3C, OK);
      wr(8'h08, 32'hE, OK);
      rd(8'h08, 32'h0, OK);
    end
    $display("test noise done");
    wr(8'h04, 32'h0, OK);
    send(9'h081, 1'h0, 4'hF, 1'h0);
    chk({31'h0, irq_seen}, 32'h0);
    rd(8'h08, 32'h5, OK);
    wr(8'h04, 32'h1, OK);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h1);
    rd(8'h0C, 32'h81, OK);
    wr(8'h08, 32'hE, OK);
    send(9'h000, 1'h0, 4'hF, 1'h0);
    rd(8'h08, 32'hD, OK);
    rd(8'h10, 32'h0, OK);
    rd(8'h0C, 32'h0, OK);
    wr(8'h08, 32'hE, OK);
    $display("test framing and break done");
    send(9'h1FF, 1'h1, 4'hF, 1'h1);
    chk({31'h0, irq_seen}, 32'h0);
    send(9'h055, 1'h1, 4'hF, 1'h0);
    rd(8'h08, 32'h1, OK);
    rd(8'h0C, 32'h55, OK);
    $display("test false start done");
    // Without realignment the drift of one tick per bit corrupts the last bits
    for (int s = 1; s < 3; s++) begin
      tx_skew <= 2'(s);
      send(9'h055, 1'h1, 4'hF, 1'h0);
      rd(8'h08, 32'h1, OK);
      rd(8'h0C, 32'h55, OK);
    end
    tx_skew <= 2'h0;
    $display("test baud skew done");
    report_and_stop();
  end
endmodule

`default_nettype wire
